// >>> bench/bus_far_end.sv
// Far side of the SCSI bus: other devices and the terminators
`timescale 1ns/100ps
`default_nettype none
module bus_far_end
    import bus_phase_pkg::*;
(
    // Pull-down requests from the block and from the far devices
    input wire logic [CTL_W-1:0] dut_ctl_oe_in,
    input wire logic [CTL_W-1:0] far_ctl_in,
    input wire logic [8:0] dut_data_oe_in,
    input wire logic [8:0] far_data_in,
    // Wire levels, low is true, parity in bit 8
    output logic [CTL_W-1:0] ctl_wire_out,
    output logic [8:0] data_wire_out
);
    // Terminators pull every released line high
    assign ctl_wire_out = ~(dut_ctl_oe_in | far_ctl_in);
    assign data_wire_out = ~(dut_data_oe_in | far_data_in);
endmodule
`default_nettype wire

// >>> bench/bus_phase_control_tb.sv
// Register level testbench of the bus phase control block
`timescale 1ns/100ps
`default_nettype none
module bus_phase_control_tb
    import bus_phase_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic cs_b = 1'b1, rd_b = 1'b1, wr_b = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, tx = 8'hA5;
    logic tgt = 1'b0, dma = 1'b0, arb = 1'b0, last = 1'b0;
    logic [CTL_W-1:0] far_ctl = '0, ctl_w, ctl_oe, ctl_o;
    logic [8:0] far_dat = '0, dat_w;
    logic [7:0] rdata, dl_oe, dl_o;
    logic rd_oe, irq, irq_oe, par_oe, par_o, s5, s6, s7, eclr, lclr;
    int mismatches = 0, checks = 0, cyc = 0;
    int n5 = 0, n6 = 0, n7 = 0, ne = 0;

    always #12.5 ref_clk_in = ~ref_clk_in;

    bus_phase_control DUT (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .cs_b_in(cs_b), .rd_b_in(rd_b), .wr_b_in(wr_b),
        .addr_in(addr), .cpu_data_in(wdata),
        .cpu_data_out(rdata), .cpu_data_oe_out(rd_oe),
        .irq_out(irq), .irq_oe_out(irq_oe),
        .target_role_in(tgt), .dma_mode_in(dma),
        .arbitration_request_bit_in(arb), .tx_data_in(tx),
        .last_byte_sent_in(last), .ctl_in(ctl_w),
        .ctl_out(ctl_o), .ctl_oe_out(ctl_oe),
        .bus_data_lines_in(dat_w[7:0]), .bus_data_lines_out(dl_o),
        .bus_data_lines_oe_out(dl_oe),
        .bus_parity_line_in(dat_w[8]), .bus_parity_line_out(par_o),
        .bus_parity_line_oe_out(par_oe),
        .start_send_out(s5), .start_target_rx_out(s6),
        .start_init_rx_out(s7), .error_clear_out(eclr),
        .logic_clear_out(lclr)
    );

    bus_far_end far (
        .dut_ctl_oe_in(ctl_oe), .far_ctl_in(far_ctl),
        .dut_data_oe_in({par_oe, dl_oe}), .far_data_in(far_dat),
        .ctl_wire_out(ctl_w), .data_wire_out(dat_w)
    );

    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Pulse counters and hang limit
    always @(posedge ref_clk_in) begin
        cyc++;
        n5 += int'(s5);
        n6 += int'(s6);
        n7 += int'(s7);
        ne += int'(eclr);
        if (cyc == 3000) begin
            mismatches++;
            results();
        end
    end

    function automatic logic [8:0] b(input int i);
        return 9'h001 << i;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
        // Hand back on a rising edge so the next stimulus lands on it
        @(posedge ref_clk_in);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        cs_b <= 1'b0;
        wr_b <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_in);
        cs_b <= 1'b1;
        wr_b <= 1'b1;
        tick(4);
        #1;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        cs_b <= 1'b0;
        rd_b <= 1'b0;
        addr <= a;
        tick(3);
        #1;
        chk({7'h00, rd_oe, rdata}, {8'h01, e});
        cs_b <= 1'b1;
        rd_b <= 1'b1;
        tick(4);
        #1;
    endtask

    task automatic settle;
        tick(4);
        #1;
    endtask

    initial begin
        tick(4);
        rst_b_in <= 1'b1;
        tick(2);
        far_ctl <= b(CTL_REQ) | b(CTL_MSG) | b(CTL_IO) | b(CTL_SEL);
        far_dat <= 9'h100;
        rd(REG_BUS_MON, 8'h37);
        @(posedge ref_clk_in);
        far_ctl <= '0;
        far_dat <= '0;
        wr(REG_INIT_CMD, 8'h1E);
        chk(ctl_oe, b(CTL_ACK) | b(CTL_BSY) | b(CTL_SEL) | b(CTL_ATN));
        rd(REG_INIT_CMD, 8'h1E);
        tgt <= 1'b1;
        settle();
        chk(ctl_oe, b(CTL_BSY) | b(CTL_SEL));
        wr(REG_INIT_CMD, 8'h00);
        chk(ctl_oe, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            if (i == 4 || i == 5) continue;
            wr(REG_TGT_CMD, 8'h08 | 8'(i));
            chk(ctl_oe, b(CTL_REQ) | 9'(i));
        end
        last <= 1'b1;
        rd(REG_TGT_CMD, 8'h8F);
        @(posedge ref_clk_in);
        last <= 1'b0;
        wr(REG_TGT_CMD, 8'h07);
        chk(ctl_oe, 9'h007);
        tgt <= 1'b0;
        settle();
        chk(ctl_oe, 16'h0000);
        wr(REG_TGT_CMD, 8'h00);
        wr(REG_INIT_CMD, 8'h01);
        chk({par_oe, dl_oe}, 9'h1A5);
        chk({7'h00, ctl_o}, 16'h0000);
        chk({7'h00, par_o, dl_o}, 16'h0000);
        far_ctl <= b(CTL_IO);
        settle();
        chk({par_oe, dl_oe}, 9'h000);
        tgt <= 1'b1;
        settle();
        chk({par_oe, dl_oe}, 9'h1A5);
        tgt <= 1'b0;
        far_ctl <= '0;
        wr(REG_INIT_CMD, 8'h00);
        @(posedge ref_clk_in);
        dma <= 1'b1;
        wr(REG_TGT_CMD, 8'h03);
        @(posedge ref_clk_in);
        far_ctl <= b(CTL_REQ);
        settle();
        chk(irq, 1'b1);
        far_ctl <= '0;
        rd(REG_ERR_CLEAR, 8'h00);
        chk({13'(ne), 3'(irq)}, 16'h0008);
        wr(REG_TGT_CMD, 8'h00);
        wr(REG_SEL_ID, 8'h04);
        @(posedge ref_clk_in);
        far_dat <= 9'h004;
        far_ctl <= b(CTL_SEL);
        settle();
        chk(irq, 1'b1);
        far_ctl <= '0;
        far_dat <= '0;
        rd(REG_ERR_CLEAR, 8'h00);
        chk(irq, 1'b0);
        wr(REG_DMA_SEND, 8'hFF);
        @(posedge ref_clk_in);
        tgt <= 1'b1;
        wr(REG_DMA_TGT_RX, 8'h00);
        @(posedge ref_clk_in);
        tgt <= 1'b0;
        wr(REG_DMA_INIT_RX, 8'h5A);
        chk({4'(n5), 4'(n6), 4'(n7)}, 12'h111);
        chk(ctl_oe, 16'h0000);
        dma <= 1'b0;
        arb <= 1'b1;
        tick(20);
        rd(REG_INIT_CMD, 8'h40);
        chk({par_oe, dl_oe}, 9'h1A5);
        far_ctl <= b(CTL_SEL);
        settle();
        rd(REG_INIT_CMD, 8'h60);
        @(posedge ref_clk_in);
        arb <= 1'b0;
        far_ctl <= '0;
        settle();
        rd(REG_INIT_CMD, 8'h00);
        // Own ID on the bus met the foreign SEL: clear that interrupt first
        rd(REG_ERR_CLEAR, 8'h00);
        chk(irq, 1'b0);
        wr(REG_INIT_CMD, 8'h1E);
        wr(REG_INIT_CMD, 8'h80);
        chk({irq, lclr, ctl_oe}, {2'b11, b(CTL_RST)});
        rd(REG_INIT_CMD, 8'h80);
        rd(REG_ERR_CLEAR, 8'h00);
        chk(irq, 1'b1);
        wr(REG_INIT_CMD, 8'h00);
        rd(REG_ERR_CLEAR, 8'h00);
        chk({irq, ctl_oe}, 16'h0000);
        wr(REG_INIT_CMD, 8'h42);
        chk({irq_oe, ctl_oe}, 16'h0000);
        rst_b_in <= 1'b0;
        tick(4);
        rst_b_in <= 1'b1;
        settle();
        chk({irq_oe, ctl_oe}, 16'h0200);
        results();
    end
endmodule
`default_nettype wire

// >>> design/bus_phase_control.sv
// Bus signal control, arbitration and monitoring core
`timescale 1ns/100ps
`default_nettype none
module bus_phase_control
    import bus_phase_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // CPU port
    input wire logic cs_b_in,
    input wire logic rd_b_in,
    input wire logic wr_b_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] cpu_data_in,
    output logic [7:0] cpu_data_out,
    output logic cpu_data_oe_out,
    output logic irq_out,
    output logic irq_oe_out,
    // Mode bits and DMA engine status
    input wire logic target_role_in,
    input wire logic dma_mode_in,
    input wire logic arbitration_request_bit_in,
    input wire logic [7:0] tx_data_in,
    input wire logic last_byte_sent_in,
    // SCSI control lines, wire level, low is true
    input wire logic [CTL_W-1:0] ctl_in,
    output logic [CTL_W-1:0] ctl_out,
    output logic [CTL_W-1:0] ctl_oe_out,
    // SCSI data and parity, wire level, low is true
    input wire logic [7:0] bus_data_lines_in,
    output logic [7:0] bus_data_lines_out,
    output logic [7:0] bus_data_lines_oe_out,
    input wire logic bus_parity_line_in,
    output logic bus_parity_line_out,
    output logic bus_parity_line_oe_out,
    // Strobes to the DMA engine and mode register
    output logic start_send_out,
    output logic start_target_rx_out,
    output logic start_init_rx_out,
    output logic error_clear_out,
    output logic logic_clear_out
);
    cpu_access_if acc ();

    logic icr_rst_reg;
    logic test_mode_reg;
    logic [4:0] icr_low_reg;
    logic [3:0] tcr_reg;
    logic [7:0] sel_id_reg;
    arb_state_t arb_reg;
    arb_state_t arb_next;
    logic [4:0] free_cnt_reg;
    logic req_prev_reg;
    logic match_prev_reg;
    logic [CTL_W-1:0] live;
    logic [7:0] data_live;
    logic par_live;
    logic bus_free;
    logic phase_match;
    logic id_match;
    logic mismatch_evt;
    logic sel_evt;
    logic irq_set;
    logic irq_clr;
    logic tx_parity;
    logic drive_data;
    logic arb_active;
    logic [CTL_W-1:0] ctl_drive;
    logic [7:0] read_mux;
    logic wr_icr;
    logic wr_tcr;

    cpu_strobe_decode u_decode (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .cs_b_in(cs_b_in),
        .rd_b_in(rd_b_in),
        .wr_b_in(wr_b_in),
        .addr_in(addr_in),
        .cpu_data_in(cpu_data_in),
        .acc(acc)
    );

    odd_parity_gen #(.WIDTH(8)) u_parity (
        .data_in(tx_data_in),
        .parity_out(tx_parity)
    );

    // Bus lines are active low; live holds true-high copies
    assign live = ~ctl_in;
    assign data_live = ~bus_data_lines_in;
    assign par_live = ~bus_parity_line_in;
    assign wr_icr = acc.wr_stb && acc.addr == REG_INIT_CMD;
    assign wr_tcr = acc.wr_stb && acc.addr == REG_TGT_CMD;
    assign phase_match = live[CTL_MSG:CTL_IO] == tcr_reg[2:0];
    assign id_match = (data_live & sel_id_reg) != BYTE_ZERO
        && !live[CTL_BSY] && live[CTL_SEL];
    assign arb_active = arb_reg == ARB_RUN;
    assign bus_free = free_cnt_reg == 5'(BUS_FREE_CYC);

    assign mismatch_evt = !target_role_in && dma_mode_in && !phase_match
        && live[CTL_REQ] && !req_prev_reg;
    assign sel_evt = id_match && !match_prev_reg;
    assign irq_set = icr_rst_reg || mismatch_evt || sel_evt;
    // clear on read of the clear address
    assign irq_clr = acc.rd_end && acc.addr == REG_ERR_CLEAR;

    // only rst_b_in or an initiator command write with the test bit low clears the test bit
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            test_mode_reg <= 1'b0;
        end else if (wr_icr) begin
            test_mode_reg <= acc.wdata[ICR_TEST];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            icr_rst_reg <= 1'b0;
        end else if (wr_icr) begin
            icr_rst_reg <= acc.wdata[ICR_RST];
        end
    end

    // command bits held clear while reset bit is set
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            icr_low_reg <= ICR_LOW_RESET;
            tcr_reg <= TCR_RESET;
            sel_id_reg <= BYTE_ZERO;
        end else if (icr_rst_reg) begin
            icr_low_reg <= ICR_LOW_RESET;
            tcr_reg <= TCR_RESET;
            sel_id_reg <= BYTE_ZERO;
        end else begin
            if (wr_icr) begin
                icr_low_reg <= acc.wdata[4:0];
            end
            if (wr_tcr) begin
                tcr_reg <= acc.wdata[3:0];
            end
            if (acc.wr_stb && acc.addr == REG_SEL_ID) begin
                sel_id_reg <= acc.wdata;
            end
        end
    end

    // Bus free once BSY and SEL stay false for the settle time
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            free_cnt_reg <= 5'h00;
        end else if (live[CTL_BSY] || live[CTL_SEL]) begin
            free_cnt_reg <= 5'h00;
        end else if (!bus_free) begin
            free_cnt_reg <= free_cnt_reg + 5'h01;
        end
    end

    always_comb begin
        arb_next = arb_reg;
        case (arb_reg)
            ARB_IDLE: begin
                if (arbitration_request_bit_in) begin
                    arb_next = ARB_WAIT;
                end
            end
            ARB_WAIT: begin
                // arbitration starts on a free bus
                if (bus_free) begin
                    arb_next = ARB_RUN;
                end
            end
            ARB_RUN: begin
                if (live[CTL_SEL] && !icr_low_reg[ICR_SEL]) begin
                    arb_next = ARB_LOST;
                end
            end
            ARB_LOST: arb_next = ARB_LOST;
            default: arb_next = ARB_IDLE;
        endcase
        if (!arbitration_request_bit_in || icr_rst_reg) begin
            arb_next = ARB_IDLE;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            arb_reg <= ARB_IDLE;
        end else begin
            arb_reg <= arb_next;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            req_prev_reg <= 1'b0;
            match_prev_reg <= 1'b0;
        end else begin
            req_prev_reg <= live[CTL_REQ];
            match_prev_reg <= id_match;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_out <= 1'b0;
        end else if (irq_set) begin
            irq_out <= 1'b1;
        end else if (irq_clr) begin
            irq_out <= 1'b0;
        end
    end

    always_comb begin
        ctl_drive = '0;
        ctl_drive[CTL_RST] = icr_rst_reg;
        ctl_drive[CTL_BSY] = icr_low_reg[ICR_BSY];
        ctl_drive[CTL_SEL] = icr_low_reg[ICR_SEL];
        ctl_drive[CTL_ATN] = icr_low_reg[ICR_ATN] && !target_role_in;
        ctl_drive[CTL_ACK] = icr_low_reg[ICR_ACK] && !target_role_in;
        ctl_drive[CTL_REQ] = tcr_reg[TCR_REQ] && target_role_in;
        ctl_drive[CTL_MSG] = tcr_reg[2] && target_role_in;
        ctl_drive[CTL_CD] = tcr_reg[1] && target_role_in;
        ctl_drive[CTL_IO] = tcr_reg[0] && target_role_in;
        if (test_mode_reg) begin
            ctl_drive = '0;
        end
    end

    always_comb begin
        drive_data = 1'b0;
        if (arb_active) begin
            // arbitration puts the ID out regardless of role and phase, except in test mode
            drive_data = 1'b1;
        end else if (target_role_in) begin
            drive_data = icr_low_reg[ICR_DATA];
        end else begin
            // initiator needs match and I/O inactive
            drive_data = icr_low_reg[ICR_DATA] && phase_match
                && !live[CTL_IO];
        end
        if (test_mode_reg) begin
            drive_data = 1'b0;
        end
    end

    // open drain pulls low for each true bit and parity
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_out <= '0;
            ctl_oe_out <= '0;
            bus_data_lines_out <= BYTE_ZERO;
            bus_data_lines_oe_out <= BYTE_ZERO;
            bus_parity_line_out <= 1'b0;
            bus_parity_line_oe_out <= 1'b0;
        end else begin
            ctl_out <= '0;
            ctl_oe_out <= ctl_drive;
            bus_data_lines_out <= BYTE_ZERO;
            bus_data_lines_oe_out <= tx_data_in & {8{drive_data}};
            bus_parity_line_out <= 1'b0;
            bus_parity_line_oe_out <= tx_parity && drive_data;
        end
    end

    always_comb begin
        read_mux = BYTE_ZERO;
        case (acc.addr)
            REG_INIT_CMD: read_mux = {icr_rst_reg, arb_reg != ARB_IDLE
                && arb_reg != ARB_WAIT, arb_reg == ARB_LOST, icr_low_reg};
            // last byte flag, bits 6 to 4 zero
            REG_TGT_CMD: read_mux = {last_byte_sent_in, 3'h0, tcr_reg};
            REG_BUS_MON: read_mux = {live[CTL_RST], live[CTL_BSY],
                live[CTL_REQ], live[CTL_MSG], live[CTL_CD],
                live[CTL_IO], live[CTL_SEL], par_live};
            default: read_mux = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cpu_data_out <= BYTE_ZERO;
            cpu_data_oe_out <= 1'b0;
            irq_oe_out <= 1'b0;
        end else begin
            cpu_data_out <= read_mux;
            // CPU side drivers off in test mode
            cpu_data_oe_out <= acc.rd_on && !test_mode_reg
                && (acc.addr == REG_INIT_CMD || acc.addr == REG_TGT_CMD
                || acc.addr == REG_BUS_MON || acc.addr == REG_ERR_CLEAR);
            irq_oe_out <= !test_mode_reg;
        end
    end

    // start strobes ignore the data lines
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_send_out <= 1'b0;
            start_target_rx_out <= 1'b0;
            start_init_rx_out <= 1'b0;
            error_clear_out <= 1'b0;
            logic_clear_out <= 1'b0;
        end else begin
            start_send_out <= acc.wr_stb && acc.addr == REG_DMA_SEND;
            start_target_rx_out <= acc.wr_stb && acc.addr == REG_DMA_TGT_RX;
            start_init_rx_out <= acc.wr_stb && acc.addr == REG_DMA_INIT_RX;
            // busy and parity error clear pulse
            error_clear_out <= irq_clr;
            // mode register and DMA engine held clear
            logic_clear_out <= icr_rst_reg;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    rst_irq_a: assert property (icr_rst_reg |=> irq_out)
        else $error("reset bit did not raise irq");
    rst_clear_a: assert property ($past(icr_rst_reg) && icr_rst_reg
        |-> icr_low_reg == ICR_LOW_RESET && tcr_reg == TCR_RESET
        && arb_reg == ARB_IDLE)
        else $error("state not cleared under reset bit");
    arb_drop_a: assert property (!arbitration_request_bit_in
        |=> arb_reg == ARB_IDLE)
        else $error("arbitration flag kept after request drop");
    test_tristate_a: assert property (test_mode_reg |=> ctl_oe_out == '0
        && bus_data_lines_oe_out == BYTE_ZERO && !cpu_data_oe_out)
        else $error("driver active in test mode");
    lost_sel_a: assert property (arb_reg == ARB_RUN && live[CTL_SEL]
        && !icr_low_reg[ICR_SEL] && arbitration_request_bit_in
        && !icr_rst_reg |=> arb_reg == ARB_LOST)
        else $error("lost arbitration not flagged");
    ack_role_a: assert property (ctl_oe_out[CTL_ACK]
        |-> $past(icr_low_reg[ICR_ACK] && !target_role_in))
        else $error("ack driven outside initiator role");
    sel_follow_a: assert property (##1 ctl_oe_out[CTL_SEL]
        == $past(icr_low_reg[ICR_SEL] && !test_mode_reg))
        else $error("sel line does not follow its bit");
    req_role_a: assert property (ctl_oe_out[CTL_REQ]
        |-> $past(target_role_in && tcr_reg[TCR_REQ]))
        else $error("req driven outside target role");
    init_data_a: assert property (bus_data_lines_oe_out != BYTE_ZERO
        && !$past(target_role_in) && !$past(arb_active)
        |-> $past(phase_match && !live[CTL_IO]))
        else $error("initiator drove data without match");
    parity_odd_a: assert property ($past(drive_data)
        |-> ^{bus_data_lines_oe_out, bus_parity_line_oe_out})
        else $error("driven parity is not odd");
    irq_clear_a: assert property (irq_clr && !irq_set
        |=> !irq_out && error_clear_out)
        else $error("clear read left irq set");
    dma_start_a: assert property (acc.wr_stb && acc.addr == REG_DMA_SEND
        |=> start_send_out ##1 !start_send_out)
        else $error("send start strobe missing");

    arb_win_c: cover property (arb_reg == ARB_WAIT ##1 arb_reg == ARB_RUN);
    arb_lost_c: cover property (arb_reg == ARB_RUN ##1 arb_reg == ARB_LOST);
    selection_c: cover property (sel_evt ##1 irq_out);
    mismatch_c: cover property (mismatch_evt ##1 irq_out);
endmodule
`default_nettype wire

// >>> design/cpu_strobe_decode.sv
// Turns chip select and read/write strobes into access pulses
`timescale 1ns/100ps
`default_nettype none
module cpu_strobe_decode (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // CPU pins
    input wire logic cs_b_in,
    input wire logic rd_b_in,
    input wire logic wr_b_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] cpu_data_in,
    // Decoded accesses
    cpu_access_if.dec acc
);
    logic wr_now;
    logic rd_now;
    logic wr_prev_reg;

    assign wr_now = !cs_b_in && !wr_b_in;
    assign rd_now = !cs_b_in && !rd_b_in;

    // Write taken once at the start of the strobe, read clear at its end
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_prev_reg <= 1'b0;
            acc.wr_stb <= 1'b0;
            acc.rd_on <= 1'b0;
            acc.rd_end <= 1'b0;
            acc.addr <= 3'h0;
            acc.wdata <= 8'h00;
        end else begin
            wr_prev_reg <= wr_now;
            acc.wr_stb <= wr_now && !wr_prev_reg;
            acc.rd_on <= rd_now;
            acc.rd_end <= acc.rd_on && !rd_now;
            if (wr_now || rd_now) begin
                acc.addr <= addr_in;
                acc.wdata <= cpu_data_in;
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/odd_parity_gen.sv
// Odd parity bit for a data word
`timescale 1ns/100ps
`default_nettype none
module odd_parity_gen #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] data_in,
    output logic parity_out
);
    // Data plus parity always holds an odd number of ones
    assign parity_out = ~^data_in;
endmodule
`default_nettype wire

// >>> pkg/bus_phase_pkg.sv
// Register map, bit positions and timing constants of the bus phase block
package bus_phase_pkg;
    // Register addresses on the three-bit CPU address
    localparam logic [2:0] REG_INIT_CMD = 3'h1;
    localparam logic [2:0] REG_TGT_CMD = 3'h3;
    localparam logic [2:0] REG_BUS_MON = 3'h4;
    localparam logic [2:0] REG_SEL_ID = 3'h4;
    localparam logic [2:0] REG_DMA_SEND = 3'h5;
    localparam logic [2:0] REG_DMA_TGT_RX = 3'h6;
    localparam logic [2:0] REG_DMA_INIT_RX = 3'h7;
    localparam logic [2:0] REG_ERR_CLEAR = 3'h7;

    // Initiator bus command bits
    localparam int ICR_RST = 7;
    localparam int ICR_TEST = 6;
    localparam int ICR_ARB_PROG = 6;
    localparam int ICR_ARB_LOST = 5;
    localparam int ICR_ACK = 4;
    localparam int ICR_BSY = 3;
    localparam int ICR_SEL = 2;
    localparam int ICR_ATN = 1;
    localparam int ICR_DATA = 0;
    localparam logic [4:0] ICR_LOW_RESET = 5'h00;

    // Target phase command bits
    localparam int TCR_LAST = 7;
    localparam int TCR_REQ = 3;
    localparam logic [3:0] TCR_RESET = 4'h0;

    // Index of each control line in the control line vectors
    localparam int CTL_IO = 0;
    localparam int CTL_CD = 1;
    localparam int CTL_MSG = 2;
    localparam int CTL_REQ = 3;
    localparam int CTL_BSY = 4;
    localparam int CTL_RST = 5;
    localparam int CTL_SEL = 6;
    localparam int CTL_ATN = 7;
    localparam int CTL_ACK = 8;
    localparam int CTL_W = 9;

    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Bus settle time before a free bus is recognised
    localparam int CLK_PERIOD_NS = 25;
    localparam int BUS_FREE_NS = 400;
    localparam int BUS_FREE_CYC =
        (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_WAIT = 2'b01,
        ARB_RUN = 2'b11,
        ARB_LOST = 2'b10
    } arb_state_t;
endpackage

// >>> pkg/cpu_access_if.sv
// Decoded CPU register accesses passed from the strobe decoder to the core
`timescale 1ns/100ps
`default_nettype none
interface cpu_access_if;
    logic wr_stb;
    logic rd_on;
    logic rd_end;
    logic [2:0] addr;
    logic [7:0] wdata;

    modport dec (output wr_stb, rd_on, rd_end, addr, wdata);
    modport core (input wr_stb, rd_on, rd_end, addr, wdata);
endinterface
`default_nettype wire
